//--- hw/iccr_pkg.sv
// Constants and types shared by the I/O cell control routing block
// Behaviour
// - Each I/O cell picks clock, clear, clock enable, output enable from bank lines.
// - Bank has twelve lines: eight output enables, six clock enables, two clocks, two clears.
// - Cells may take clock and output enables directly from logic cells instead.
// - Cells may also clock from either of two dedicated clock pins.
// - Bank lines come from dedicated pins, cluster first cells, or a column feed.
// - Chip-wide reset low clears every cell register, overriding all other controls.
// - Lines 0-5 are output enables; lines 6-11 clock enables sharing clocks, clears, enables.
// - Four bank lines may drive the four global signals.
// - An internally driven global ignores its dedicated pin; board ties that pin.
// - Enabled chip-wide output enable held low turns every pin driver off.
// - An input cell drives two row channels.
// - An output cell takes its value from a row channel multiplexer.
// - Each cell reaches its own subset of row channels, e.g. 18 of 144.
// - Input cells drive two column channels; output cells may use column channels.
// - Each cell reaches a column channel set differing from all other cells.
// - Column multiplexer reaches 16 of 24, 24 of 32 or 32 of 40 channels.
// - Each cell has a pin buffer and one register for capture or launch.
// - Six dedicated low-skew input pins feed controls to all cells.
package iccr_pkg;
    // ****************************************
    // Bank layout
    // ****************************************
    localparam int N_LINES = 12;
    localparam int N_DED = 6;
    localparam int N_GLB = 4;
    localparam int N_DCLK = 2;
    localparam int N_OE_ONLY = 6;
    localparam int L_CE_A = 6;
    localparam int L_CLK_A = 6;
    localparam int L_OE_G = 7;
    localparam int L_CLR_A = 8;
    localparam int L_OE_H = 9;
    localparam int L_CLR_B = 10;
    localparam int L_CLK_B = 11;
    localparam int L_GLB_A = 6;
    localparam int L_GLB_B = 7;
    localparam int L_GLB_C = 9;
    localparam int L_GLB_D = 11;
    localparam int LKIND_W = 2;
    localparam int LIDX_W = 4;
    // ****************************************
    // Cell selector codes
    // ****************************************
    localparam int CE_W = 3;
    localparam logic [2:0] CE_NONE = 3'h0;
    localparam logic [2:0] CE_LAST = 3'h6;
    localparam logic [2:0] CE_LOGIC = 3'h7;
    localparam int OE_W = 4;
    localparam logic [3:0] OE_NONE = 4'h0;
    localparam logic [3:0] OE_SIXTH = 4'h6;
    localparam logic [3:0] OE_G = 4'h7;
    localparam logic [3:0] OE_H = 4'h8;
    localparam logic [3:0] OE_LOGIC = 4'h9;
    localparam int CLR_W = 2;
    localparam logic [1:0] CLR_NONE = 2'h0;
    localparam logic [1:0] CLR_A = 2'h1;
    localparam logic [1:0] CLR_B = 2'h2;
    // ****************************************
    // Channel sizes and reset values
    // ****************************************
    localparam int ROW_CH_DEF = 144;
    localparam int ROW_PER_PIN_DEF = 18;
    localparam int COL_CH_DEF = 24;
    localparam int COL_PER_PIN_DEF = 16;
    localparam logic IDLE_HI = 1'b1;
    localparam logic IDLE_LO = 1'b0;
    typedef enum logic [1:0] {SRC_DED, SRC_CLUS, SRC_COL, SRC_OFF} iccr_src_t;
    typedef enum logic [1:0] {CK_BANK_A, CK_BANK_B, CK_PIN_A, CK_PIN_B} iccr_clk_t;
endpackage : iccr_pkg

//--- hw/iccr_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module iccr_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    import iccr_pkg::*;
    logic [W-1:0] s1_q, s2_q, s3_q;
    // ****************************************
    // Stages; output moves when stages two and three agree
    // ****************************************
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s1_q <= RST_VAL;
            s2_q <= RST_VAL;
            s3_q <= RST_VAL;
            q <= RST_VAL;
        end
        else
        begin
            s1_q <= d;
            s2_q <= s1_q;
            s3_q <= s2_q;
            q <= (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & q);
        end
    end
endmodule : iccr_sync

//--- hw/iccr_bank.sv
// Peripheral control line bank source selection
`timescale 1ns/1ps
module iccr_bank #(
    parameter int N_CLUS = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [iccr_pkg::N_DED-1:0] ded,
    input wire logic [iccr_pkg::N_LINES*iccr_pkg::LKIND_W-1:0] kind,
    input wire logic [iccr_pkg::N_LINES*iccr_pkg::LIDX_W-1:0] idx,
    input wire logic [iccr_pkg::N_LINES*N_CLUS-1:0] clus,
    input wire logic [iccr_pkg::N_LINES-1:0] colf,
    output logic [iccr_pkg::N_LINES-1:0] lines
);
    import iccr_pkg::*;
    logic [N_LINES-1:0] line_d;
    // ****************************************
    // Per-line source multiplexer
    // ****************************************
    always_comb
    begin
        int ix;
        ix = 0;
        line_d = '0;
        for (int l = 0; l < N_LINES; l++)
        begin
            ix = int'(idx[l*LIDX_W +: LIDX_W]);
            unique case (iccr_src_t'(kind[l*LKIND_W +: LKIND_W]))
                SRC_DED: line_d[l] = (ix < N_DED) ? ded[ix] : IDLE_LO;
                SRC_CLUS: line_d[l] = (ix < N_CLUS) ? clus[l*N_CLUS+ix] : IDLE_LO;
                SRC_COL: line_d[l] = colf[l];
                SRC_OFF: line_d[l] = IDLE_LO;
            endcase
        end
    end
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            lines <= '0;
        else
            lines <= line_d;
    end
endmodule : iccr_bank

//--- hw/iccr_top.sv
// I/O cell array with peripheral control routing and channel multiplexers
`timescale 1ns/1ps
module iccr_top #(
    parameter int N_IO = 8,
    parameter int N_CLUS = 8,
    parameter int ROW_CH = iccr_pkg::ROW_CH_DEF,
    parameter int ROW_PER_PIN = iccr_pkg::ROW_PER_PIN_DEF,
    parameter int COL_CH = iccr_pkg::COL_CH_DEF,
    parameter int COL_PER_PIN = iccr_pkg::COL_PER_PIN_DEF,
    parameter int ROW_SW = $clog2(ROW_PER_PIN),
    parameter int COL_SW = $clog2(COL_PER_PIN)
) (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic [N_IO-1:0] PAD_I,
    output logic [N_IO-1:0] PAD_O,
    output logic [N_IO-1:0] PAD_OE,
    input wire logic [iccr_pkg::N_DED-1:0] DED_IN,
    input wire logic [iccr_pkg::N_DCLK-1:0] DCLK_IN,
    input wire logic CHIP_RST_N,
    input wire logic CHIP_OE_N,
    input wire logic CHIP_OE_USE,
    input wire logic [iccr_pkg::N_LINES*iccr_pkg::LKIND_W-1:0] LINE_KIND,
    input wire logic [iccr_pkg::N_LINES*iccr_pkg::LIDX_W-1:0] LINE_IDX,
    input wire logic [iccr_pkg::N_LINES*N_CLUS-1:0] CLUS_FIRST,
    input wire logic [iccr_pkg::N_LINES-1:0] COL_FEED,
    output logic [iccr_pkg::N_LINES-1:0] BANK_LINES,
    input wire logic [iccr_pkg::N_GLB-1:0] GLB_INT,
    output logic [iccr_pkg::N_GLB-1:0] GLOBAL_OUT,
    input wire logic [N_IO-1:0] LC_CE,
    input wire logic [N_IO-1:0] LC_OE,
    input wire logic [N_IO-1:0] CELL_OUT,
    input wire logic [N_IO-1:0] CELL_REG,
    input wire logic [N_IO-1:0] CELL_COL,
    input wire logic [2*N_IO-1:0] CELL_CLK,
    input wire logic [iccr_pkg::CE_W*N_IO-1:0] CELL_CE,
    input wire logic [iccr_pkg::OE_W*N_IO-1:0] CELL_OE,
    input wire logic [iccr_pkg::CLR_W*N_IO-1:0] CELL_CLR,
    input wire logic [ROW_SW*N_IO-1:0] CELL_ROW,
    input wire logic [COL_SW*N_IO-1:0] CELL_CSEL,
    input wire logic [ROW_CH-1:0] ROW_CH_IN,
    input wire logic [COL_CH-1:0] COL_CH_IN,
    output logic [2*N_IO-1:0] ROW_DRV,
    output logic [2*N_IO-1:0] COL_DRV
);
    import iccr_pkg::*;
    localparam int W_SYNC = N_IO + N_DED + N_DCLK + 2;
    localparam logic [W_SYNC-1:0] SYNC_RST = {IDLE_HI, IDLE_HI, {(W_SYNC-2){IDLE_LO}}};

    logic [N_IO-1:0] pad_s;
    logic [N_DED-1:0] ded_s, ded_use;
    logic [N_DCLK-1:0] dclk_s;
    logic chip_rst_n_s, chip_oe_n_s, oe_kill;
    logic [N_LINES-1:0] bank;
    logic [N_GLB-1:0] glb_q;
    logic [3:0] clk_src, clk_prev_q, clk_rise;
    logic [N_IO-1:0] cell_q, pad_o_q, pad_oe_q;
    logic [N_IO-1:0] tick, ce_ok, clr_hit, oe_on, d_in, out_mux, row_pick, col_pick;
    logic [2*N_IO-1:0] row_drv_q, col_drv_q;

    // ****************************************
    // Decode helpers
    // ****************************************
    function automatic int ce_line(input logic [CE_W-1:0] sel);
        return L_CE_A + int'(sel) - 1;
    endfunction : ce_line

    function automatic int oe_line(input logic [OE_W-1:0] sel);
        int r;
        r = 0;
        if (sel == OE_G)
            r = L_OE_G;
        else if (sel == OE_H)
            r = L_OE_H;
        else
            r = int'(sel) - 1;
        return r;
    endfunction : oe_line

    function automatic int glb_line(input int k);
        int r;
        r = L_GLB_A;
        unique case (k)
            1: r = L_GLB_B;
            2: r = L_GLB_C;
            3: r = L_GLB_D;
            default: r = L_GLB_A;
        endcase
        return r;
    endfunction : glb_line

    // Each cell owns a disjoint slice of the row channels
    function automatic int row_chan(input int i, input logic [ROW_SW-1:0] sel);
        int s;
        s = (int'(sel) < ROW_PER_PIN) ? int'(sel) : 0;
        return (i * ROW_PER_PIN + s) % ROW_CH;
    endfunction : row_chan

    // Sliding window: each cell's column set starts one channel later
    function automatic int col_chan(input int i, input logic [COL_SW-1:0] sel);
        int s;
        s = (int'(sel) < COL_PER_PIN) ? int'(sel) : 0;
        return (i + s) % COL_CH;
    endfunction : col_chan

    // ****************************************
    // Pin synchronisers
    // ****************************************
    iccr_sync #(
        .W(W_SYNC),
        .RST_VAL(SYNC_RST)
    ) u_sync (
        .clk(CLK_SYS),
        .rst(RST),
        .d({CHIP_OE_N, CHIP_RST_N, DCLK_IN, DED_IN, PAD_I}),
        .q({chip_oe_n_s, chip_rst_n_s, dclk_s, ded_s, pad_s})
    );

    // ****************************************
    // Dedicated inputs and control bank
    // ****************************************
    // A pin whose global is taken by internal logic is ignored
    assign ded_use = ded_s & ~{{(N_DED-N_GLB){IDLE_LO}}, GLB_INT};

    iccr_bank #(
        .N_CLUS(N_CLUS)
    ) u_bank (
        .clk(CLK_SYS),
        .rst(RST),
        .ded(ded_use),
        .kind(LINE_KIND),
        .idx(LINE_IDX),
        .clus(CLUS_FIRST),
        .colf(COL_FEED),
        .lines(bank)
    );
    assign BANK_LINES = bank;

    // ****************************************
    // Global distribution
    // ****************************************
    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
            glb_q <= '0;
        else
            for (int k = 0; k < N_GLB; k++)
                glb_q[k] <= GLB_INT[k] ? bank[glb_line(k)] : ded_s[k];
    end
    assign GLOBAL_OUT = glb_q;

    for (genvar k = 0; k < N_GLB; k++)
    begin : g_glb
        a_global_int: assert property (@(posedge CLK_SYS) disable iff (RST)
            GLB_INT[k] |=> glb_q[k] == $past(bank[glb_line(k)]))
            else $error("global not following bank line");
        a_global_pin: assert property (@(posedge CLK_SYS) disable iff (RST)
            !GLB_INT[k] |=> glb_q[k] == $past(ded_s[k]))
            else $error("global not following dedicated pin");
        for (genvar l = 0; l < N_LINES; l++)
        begin : g_line
            a_ded_masked: assert property (@(posedge CLK_SYS) disable iff (RST)
                (GLB_INT[k] && LINE_KIND[LKIND_W*l +: LKIND_W] == SRC_DED
                && LINE_IDX[LIDX_W*l +: LIDX_W] == k) |=> !bank[l])
                else $error("dedicated pin used while global is internal");
        end
    end

    // ****************************************
    // Register clock sources and edge detect
    // ****************************************
    assign clk_src = {dclk_s[1], dclk_s[0], bank[L_CLK_B], bank[L_CLK_A]};
    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
            clk_prev_q <= '0;
        else
            clk_prev_q <= clk_src;
    end
    assign clk_rise = clk_src & ~clk_prev_q;
    assign oe_kill = CHIP_OE_USE & ~chip_oe_n_s;

    // ****************************************
    // I/O cell array
    // ****************************************
    for (genvar i = 0; i < N_IO; i++)
    begin : g_cell
        logic [CE_W-1:0] ce_sel;
        logic [OE_W-1:0] oe_sel;
        logic [CLR_W-1:0] clr_sel;
        iccr_clk_t ck_sel;
        assign ce_sel = CELL_CE[CE_W*i +: CE_W];
        assign oe_sel = CELL_OE[OE_W*i +: OE_W];
        assign clr_sel = CELL_CLR[CLR_W*i +: CLR_W];
        assign ck_sel = iccr_clk_t'(CELL_CLK[2*i +: 2]);

        // Control selection from the bank
        always_comb
        begin
            tick[i] = clk_rise[ck_sel];
            if (ce_sel == CE_NONE)
                ce_ok[i] = IDLE_HI;
            else if (ce_sel == CE_LOGIC)
                ce_ok[i] = LC_CE[i];
            else
                ce_ok[i] = bank[ce_line(ce_sel)];
            if (oe_sel == OE_NONE)
                oe_on[i] = IDLE_HI;
            else if (oe_sel == OE_LOGIC)
                oe_on[i] = LC_OE[i];
            else if (oe_sel <= OE_H)
                oe_on[i] = bank[oe_line(oe_sel)];
            else
                oe_on[i] = IDLE_LO;
            if (clr_sel == CLR_A)
                clr_hit[i] = bank[L_CLR_A];
            else if (clr_sel == CLR_B)
                clr_hit[i] = bank[L_CLR_B];
            else
                clr_hit[i] = IDLE_LO;
        end

        // Output data from row or column channels
        assign row_pick[i] = ROW_CH_IN[row_chan(i, CELL_ROW[ROW_SW*i +: ROW_SW])];
        assign col_pick[i] = COL_CH_IN[col_chan(i, CELL_CSEL[COL_SW*i +: COL_SW])];
        assign out_mux[i] = CELL_COL[i] ? col_pick[i] : row_pick[i];
        assign d_in[i] = CELL_OUT[i] ? out_mux[i] : pad_s[i];

        // Shared capture or launch register
        always_ff @(posedge CLK_SYS or posedge RST)
        begin
            if (RST)
                cell_q[i] <= IDLE_LO;
            else if (!chip_rst_n_s)
                cell_q[i] <= IDLE_LO;
            else if (clr_hit[i])
                cell_q[i] <= IDLE_LO;
            else if (tick[i] && ce_ok[i])
                cell_q[i] <= d_in[i];
        end

        // Pin driver
        always_ff @(posedge CLK_SYS or posedge RST)
        begin
            if (RST)
            begin
                pad_o_q[i] <= IDLE_LO;
                pad_oe_q[i] <= IDLE_LO;
            end
            else
            begin
                pad_o_q[i] <= CELL_REG[i] ? cell_q[i] : out_mux[i];
                pad_oe_q[i] <= CELL_OUT[i] & oe_on[i] & ~oe_kill;
            end
        end

        // Input value onto two row and two column channels
        always_ff @(posedge CLK_SYS or posedge RST)
        begin
            if (RST)
            begin
                row_drv_q[2*i +: 2] <= '0;
                col_drv_q[2*i +: 2] <= '0;
            end
            else if (!CELL_OUT[i])
            begin
                row_drv_q[2*i +: 2] <= {2{CELL_REG[i] ? cell_q[i] : pad_s[i]}};
                col_drv_q[2*i +: 2] <= {2{CELL_REG[i] ? cell_q[i] : pad_s[i]}};
            end
            else
            begin
                row_drv_q[2*i +: 2] <= '0;
                col_drv_q[2*i +: 2] <= '0;
            end
        end

        a_chip_reset: assert property (@(posedge CLK_SYS) disable iff (RST)
            !chip_rst_n_s |=> !cell_q[i])
            else $error("cell register not cleared by chip reset");
        a_no_ce_capture: assert property (@(posedge CLK_SYS) disable iff (RST)
            (tick[i] && ce_sel == CE_NONE && !clr_hit[i] && chip_rst_n_s)
            |=> cell_q[i] == $past(d_in[i]))
            else $error("cell without clock enable missed an edge");
        a_logic_ce_hold: assert property (@(posedge CLK_SYS) disable iff (RST)
            (ce_sel == CE_LOGIC && !LC_CE[i] && !clr_hit[i] && chip_rst_n_s)
            |=> $stable(cell_q[i]))
            else $error("cell captured with logic clock enable low");
        a_bank_ce_hold: assert property (@(posedge CLK_SYS) disable iff (RST)
            (ce_sel != CE_NONE && ce_sel <= CE_LAST && !bank[ce_line(ce_sel)]
            && !clr_hit[i] && chip_rst_n_s) |=> $stable(cell_q[i]))
            else $error("cell captured with bank clock enable low");
        a_pin_clock: assert property (@(posedge CLK_SYS) disable iff (RST)
            (ck_sel == CK_PIN_A && !clk_rise[CK_PIN_A] && !clr_hit[i] && chip_rst_n_s)
            |=> $stable(cell_q[i]))
            else $error("cell captured without a pin clock edge");
        a_no_oe_drive: assert property (@(posedge CLK_SYS) disable iff (RST)
            (CELL_OUT[i] && oe_sel == OE_NONE && !oe_kill) |=> pad_oe_q[i])
            else $error("output cell without enable not driving");
        a_chip_oe_off: assert property (@(posedge CLK_SYS) disable iff (RST)
            oe_kill |=> !pad_oe_q[i])
            else $error("pin driven during chip output disable");
        a_input_rows: assert property (@(posedge CLK_SYS) disable iff (RST)
            (!CELL_OUT[i] && !CELL_REG[i]) |=> row_drv_q[2*i +: 2] == {2{$past(pad_s[i])}})
            else $error("input cell not driving both row channels");
        a_input_cols: assert property (@(posedge CLK_SYS) disable iff (RST)
            (!CELL_OUT[i] && !CELL_REG[i]) |=> col_drv_q[2*i +: 2] == {2{$past(pad_s[i])}})
            else $error("input cell not driving both column channels");
        a_row_output: assert property (@(posedge CLK_SYS) disable iff (RST)
            (CELL_OUT[i] && !CELL_REG[i] && !CELL_COL[i]) |=> pad_o_q[i] == $past(row_pick[i]))
            else $error("output cell not following row channel");
        a_col_output: assert property (@(posedge CLK_SYS) disable iff (RST)
            (CELL_OUT[i] && !CELL_REG[i] && CELL_COL[i]) |=> pad_o_q[i] == $past(col_pick[i]))
            else $error("output cell not following column channel");
        a_out_launch: assert property (@(posedge CLK_SYS) disable iff (RST)
            (CELL_OUT[i] && CELL_REG[i]) |=> pad_o_q[i] == $past(cell_q[i]))
            else $error("output cell not launching from its register");
        a_reg_clear: assert property (@(posedge CLK_SYS) disable iff (RST)
            clr_hit[i] |=> !cell_q[i])
            else $error("cell register not cleared by bank clear");
        a_logic_oe: assert property (@(posedge CLK_SYS) disable iff (RST)
            (CELL_OUT[i] && oe_sel == OE_LOGIC && !oe_kill) |=> pad_oe_q[i] == $past(LC_OE[i]))
            else $error("pin enable not following logic enable");
        a_bank_oe: assert property (@(posedge CLK_SYS) disable iff (RST)
            (CELL_OUT[i] && oe_sel == OE_H && !oe_kill) |=> pad_oe_q[i] == $past(bank[L_OE_H]))
            else $error("pin enable not following shared enable line");
        a_output_quiet: assert property (@(posedge CLK_SYS) disable iff (RST)
            CELL_OUT[i] |=> {row_drv_q[2*i +: 2], col_drv_q[2*i +: 2]} == '0)
            else $error("output cell driving routing channels");
        a_bank_clock: assert property (@(posedge CLK_SYS) disable iff (RST)
            (ck_sel == CK_BANK_A && !clk_rise[CK_BANK_A] && !clr_hit[i] && chip_rst_n_s)
            |=> $stable(cell_q[i]))
            else $error("cell captured without a bank clock edge");
    end

    assign PAD_O = pad_o_q;
    assign PAD_OE = pad_oe_q;
    assign ROW_DRV = row_drv_q;
    assign COL_DRV = col_drv_q;
endmodule : iccr_top

//--- verification/iccr_far.sv
// Far-side model of the external pins and board ties of the dedicated inputs
`timescale 1ns/1ps
module iccr_far (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] ext_val,
    input wire logic [7:0] pad_o,
    input wire logic [7:0] pad_oe,
    input wire logic [5:0] ded_val,
    input wire logic [3:0] glb_int,
    output logic [7:0] pad_i,
    output logic [5:0] ded_in
);
    // ****************************************
    // Pin levels
    // ****************************************
    // Device driver wins where enabled, outside driver elsewhere
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            pad_i <= 8'h00;
        else
            pad_i <= (pad_o & pad_oe) | (ext_val & ~pad_oe);
    end
    // Dedicated pin grounded while its global is fed internally
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            ded_in <= 6'h00;
        else
            ded_in <= {ded_val[5:4], ded_val[3:0] & ~glb_int};
    end
endmodule : iccr_far

//--- verification/iccr_top_bench.sv
// Self-checking bench for the I/O cell control routing block
`timescale 1ns/1ps
module iccr_top_bench;
    import iccr_pkg::*;
    localparam int GL [4] = '{L_GLB_A, L_GLB_B, L_GLB_C, L_GLB_D};
    logic clk, rst, chip_rst_n, chip_oe_n, chip_oe_use;
    logic [7:0] pad_i, pad_o, pad_oe, ext_val, lc_ce, lc_oe, c_out, c_reg, c_col, ref8;
    logic [5:0] ded_in, ded_val;
    logic [1:0] dclk;
    logic [3:0] glb_int, glb_out;
    logic [11:0] col_feed, bank, ref12;
    logic [23:0] kind, c_ce, col_ch;
    logic [47:0] idx;
    logic [95:0] clus;
    logic [15:0] c_clk, c_clr, row_drv, col_drv, rnd;
    logic [31:0] c_oe, c_csel;
    logic [39:0] c_row;
    logic [143:0] row_ch;
    int err_total = 0;
    int checks_done = 0;

    iccr_top u_dut (.CLK_SYS(clk), .RST(rst), .PAD_I(pad_i), .PAD_O(pad_o), .PAD_OE(pad_oe),
        .DED_IN(ded_in), .DCLK_IN(dclk), .CHIP_RST_N(chip_rst_n), .CHIP_OE_N(chip_oe_n),
        .CHIP_OE_USE(chip_oe_use), .LINE_KIND(kind), .LINE_IDX(idx), .CLUS_FIRST(clus),
        .COL_FEED(col_feed), .BANK_LINES(bank), .GLB_INT(glb_int), .GLOBAL_OUT(glb_out),
        .LC_CE(lc_ce), .LC_OE(lc_oe), .CELL_OUT(c_out), .CELL_REG(c_reg), .CELL_COL(c_col),
        .CELL_CLK(c_clk), .CELL_CE(c_ce), .CELL_OE(c_oe), .CELL_CLR(c_clr), .CELL_ROW(c_row),
        .CELL_CSEL(c_csel), .ROW_CH_IN(row_ch), .COL_CH_IN(col_ch), .ROW_DRV(row_drv), .COL_DRV(col_drv));
    iccr_far u_far (.clk(clk), .rst(rst), .ext_val(ext_val), .pad_o(pad_o), .pad_oe(pad_oe),
        .ded_val(ded_val), .glb_int(glb_int), .pad_i(pad_i), .ded_in(ded_in));

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction : lfsr
    function automatic logic exp_out(input int i);
        int s;
        int c;
        s = (c_row[i*5+:5] >= 18) ? 0 : int'(c_row[i*5+:5]);
        c = (i + int'(c_csel[i*4+:4])) % COL_CH_DEF;
        return c_col[i] ? col_ch[c] : row_ch[(i * ROW_PER_PIN_DEF + s) % ROW_CH_DEF];
    endfunction : exp_out
    function automatic logic exp_line(input int l);
        int j;
        j = int'(idx[l*4+:4]);
        case (kind[l*2+:2])
            2'h0: return (j < N_GLB) ? ded_val[j] & ~glb_int[j] : ded_val[j];
            2'h1: return clus[l*8+j];
            2'h2: return col_feed[l];
            default: return 1'b0;
        endcase
    endfunction : exp_line
    function automatic logic exp_oe(input int i);
        logic [3:0] c;
        c = c_oe[i*4+:4];
        if (chip_oe_use && !chip_oe_n)
            return 1'b0;
        case (c)
            OE_NONE: return 1'b1;
            OE_G: return ref12[L_OE_G];
            OE_H: return ref12[L_OE_H];
            OE_LOGIC: return lc_oe[i];
            default: return (c <= OE_SIXTH) ? ref12[c-1] : 1'b0;
        endcase
    endfunction : exp_oe
    function automatic logic [7:0] rowbits();
        logic [7:0] v;
        for (int i = 0; i < 8; i++)
            v[i] = row_ch[i*ROW_PER_PIN_DEF];
        return v;
    endfunction : rowbits
    function automatic logic [15:0] dup(input logic [7:0] v);
        logic [15:0] d;
        for (int i = 0; i < 8; i++)
            d[i*2+:2] = {2{v[i]}};
        return d;
    endfunction : dup
    task automatic chk(input logic [15:0] got, input logic [15:0] want);
        checks_done++;
        if (got !== want)
        begin
            err_total++;
            $display("FAIL t=%0t got=%h want=%h", $time, got, want);
        end
    endtask : chk
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask : wt
    task automatic pulse(input int k);
        @(posedge clk);
        dclk <= 2'h1 << k;
        wt(6);
        dclk <= 2'h0;
        wt(6);
    endtask : pulse
    task automatic rand_fill;
        logic [303:0] p;
        for (int i = 0; i < 19; i++)
        begin
            rnd = lfsr(rnd);
            p[i*16+:16] = rnd;
        end
        row_ch <= p[143:0];
        col_ch <= p[167:144];
        clus <= p[263:168];
        col_feed <= p[275:264];
        ext_val <= p[283:276];
        ded_val <= p[289:284];
        lc_oe <= p[297:290];
        glb_int <= p[301:298];
    endtask : rand_fill
    task automatic sel_fill;
        logic [39:0] r;
        logic [31:0] cs;
        logic [31:0] oe;
        logic [23:0] kd;
        logic [47:0] ix;
        for (int i = 0; i < 12; i++)
        begin
            rnd = lfsr(rnd);
            kd[i*2+:2] = rnd[1:0];
            ix[i*4+:4] = 4'(rnd[15:2] % 6);
            if (i < 8)
            begin
                r[i*5+:5] = 5'(rnd[15:4] % 18);
                cs[i*4+:4] = rnd[7:4];
                oe[i*4+:4] = 4'(rnd[14:8] % 10);
            end
        end
        r[4:0] = 5'h11;
        cs[31:28] = 4'hf;
        c_row <= r;
        c_csel <= cs;
        c_oe <= oe;
        kind <= kd;
        idx <= ix;
    endtask : sel_fill
    task automatic stop_test;
        if (err_total == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test

    // ****************************************
    // Sequence
    // ****************************************
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial
    begin
        #20000;
        err_total++;
        stop_test;
    end
    initial
    begin
        {rst, chip_rst_n, chip_oe_n} = 3'h7;
        {chip_oe_use, dclk, glb_int, ext_val, ded_val, lc_ce, lc_oe, c_out, c_reg, c_col} = '0;
        {c_clk, c_ce, c_oe, c_clr, c_row, c_csel, idx, clus, col_feed, row_ch, col_ch} = '0;
        kind = '1;
        rnd = 16'h004b;
        wt(10);
        rst <= 1'b0;
        c_out <= 8'hff;
        for (int n = 0; n < 12; n++)
        begin
            rand_fill;
            sel_fill;
            c_col <= rnd[7:0];
            chip_oe_use <= (n == 2) ? 1'b0 : (n < 2) | rnd[3];
            chip_oe_n <= (n == 1) ? 1'b1 : (n != 0) & rnd[5];
            wt(12);
            for (int l = 0; l < 12; l++)
                ref12[l] = exp_line(l);
            chk(16'(bank), 16'(ref12));
            for (int i = 0; i < 8; i++)
            begin
                chk(16'(pad_o[i]), 16'(exp_out(i)));
                chk(16'(pad_oe[i]), 16'(exp_oe(i)));
            end
            for (int k = 0; k < 4; k++)
                chk(16'(glb_out[k]), 16'(glb_int[k] ? ref12[GL[k]] : ded_val[k]));
        end
        c_reg <= 8'hff;
        c_col <= 8'h00;
        c_row <= '0;
        c_oe <= '0;
        c_clk <= {8{2'h2}};
        kind <= {12{2'h2}};
        chip_oe_use <= 1'b0;
        rand_fill;
        col_feed <= 12'h000;
        wt(12);
        pulse(0);
        ref8 = rowbits();
        chk(16'(pad_o), 16'(ref8));
        rand_fill;
        col_feed <= 12'h000;
        wt(12);
        chk(16'(pad_o), 16'(ref8));
        c_clk <= {8{2'h3}};
        c_ce <= {8{3'h1}};
        pulse(1);
        chk(16'(pad_o), 16'(ref8));
        col_feed <= 12'h040;
        pulse(1);
        ref8 = rowbits();
        chk(16'(pad_o), 16'(ref8));
        c_clr <= {4{4'h9}};
        col_feed <= 12'h540;
        pulse(1);
        chk(16'(pad_o), 16'h0000);
        c_clr <= '0;
        c_ce <= '0;
        pulse(1);
        chk(16'(pad_o), 16'(ref8));
        chip_rst_n <= 1'b0;
        pulse(1);
        chk(16'(pad_o), 16'h0000);
        chip_rst_n <= 1'b1;
        c_ce <= {8{3'h7}};
        lc_ce <= rnd[7:0];
        pulse(1);
        chk(16'(pad_o), 16'(ref8 & lc_ce));
        c_out <= 8'h00;
        c_reg <= 8'h00;
        c_oe <= {8{4'ha}};
        repeat (4)
        begin
            rand_fill;
            wt(12);
            chk(row_drv, dup(ext_val));
            chk(col_drv, dup(ext_val));
        end
        stop_test;
    end
endmodule : iccr_top_bench
